//--- sic_clk_div.sv
// Bus clock divider for the clock output pin
`timescale 1ns/100ps
module sic_clk_div (
  input  wire logic clk_i,
  input  wire logic reset_i,
  sic_int_if.div    bus
);
  logic [2:0] cnt_reg;
  logic       out_reg;

  // Toggle every sel cycles: output period is twice sel
  always_ff @(posedge clk_i) begin
    if (reset_i || !bus.div_en || bus.div_sel == 3'h0) begin
      cnt_reg <= 3'h0;
      out_reg <= 1'b0; // [R11]
    end else if (cnt_reg >= 3'(bus.div_sel - 3'h1)) begin
      cnt_reg <= 3'h0;
      out_reg <= ~out_reg; // [R9]
    end else begin
      cnt_reg <= 3'(cnt_reg + 3'h1);
    end
  end

  assign bus.div_out = out_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_div_zero_low: assert property (bus.div_sel == 3'h0 |=> !out_reg) // [R11]
    else $error("Divider output not low for zero select");
  a_div_by_two: assert property (bus.div_en && bus.div_sel == 3'h1 && $past(bus.div_en && bus.div_sel == 3'h1)
                                 |=> out_reg != $past(out_reg)) // [R9]
    else $error("Divide by two does not toggle each cycle");
endmodule

//--- sic_far_model.sv
// Far-side model: interrupt pin source and supply comparators
`timescale 1ns/100ps
module sic_far_model (
  input  wire logic pin_lvl_i,
  input  wire logic warn_i,
  input  wire logic low_i,
  output logic      pin_o,
  output logic      below_det_high_o,
  output logic      below_det_low_o,
  output logic      below_warn_high_o,
  output logic      below_warn_low_o
);
  // Both detect trips move together, whichever level is selected
  assign below_det_high_o = low_i;
  assign below_det_low_o = low_i;
  // Both warning trips move together, whichever level is selected
  assign below_warn_high_o = warn_i;
  assign below_warn_low_o = warn_i;
  // Pin is actively driven by the source, never floating
  assign #1 pin_o = pin_lvl_i;
endmodule

//--- sic_int_if.sv
// Internal carrier between the control core, the pin detector and the clock divider
`timescale 1ns/100ps
interface sic_int_if;
  logic       pin_en;
  logic       pin_pol;
  logic       pin_mode;
  logic       pin_ack;
  logic       pin_flag;
  logic       div_en;
  logic [2:0] div_sel;
  logic       div_out;

  modport ctl (output pin_en, pin_pol, pin_mode, pin_ack, div_en, div_sel, input pin_flag, div_out);
  modport det (input pin_en, pin_pol, pin_mode, pin_ack, output pin_flag);
  modport div (input div_en, div_sel, output div_out);
endinterface

//--- sic_pin_detect.sv
// Interrupt pin synchroniser, edge and level detector and event flag
`timescale 1ns/100ps
module sic_pin_detect (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  sic_int_if.det    bus
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic flag_reg;
  logic asserted;
  logic set_evt;
  logic clr_evt;

  // Two stages before any detection logic sees the pin
  always_ff @(posedge clk_i) begin
    sync1_reg <= pin_i; // [R27]
    sync2_reg <= sync1_reg; // [R27]
  end

  assign asserted = bus.pin_pol ? sync2_reg : ~sync2_reg; // [R17]
  assign set_evt  = bus.pin_en & ((asserted & ~prev_reg) | (bus.pin_mode & asserted)); // [R18] [R22]
  assign clr_evt  = bus.pin_ack & ~(bus.pin_mode & asserted); // [R19] [R20]

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else begin
      prev_reg <= asserted;
      // Set wins over a clear in the same cycle
      flag_reg <= set_evt | (flag_reg & ~clr_evt); // [R18] [R19]
    end
  end

  assign bus.pin_flag = flag_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_level_holds_flag: assert property (bus.pin_en && bus.pin_mode && asserted |=> flag_reg) // [R20]
    else $error("Flag dropped while level asserted");
  a_edge_sets_flag: assert property (bus.pin_en && asserted && !prev_reg |=> flag_reg) // [R18]
    else $error("Edge did not set flag");
endmodule

//--- sic_pkg.sv
// Types shared by the system integration control modules
package sic_pkg;

  typedef logic [3:0] sic_addr_t;
  typedef logic [7:0] sic_byte_t;

  typedef enum logic [1:0] {
    SIC_RUN,
    SIC_STOP_DEEP,
    SIC_STOP4
  } sic_stop_e;

endpackage

//--- sic_regs.svh
// Register offsets, field positions and reset values of the system integration control block
`ifndef SIC_REGS_SVH
`define SIC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SIC_OFS_PIN_CTRL    4'h0
`define SIC_OFS_RST_STATUS  4'h1
`define SIC_OFS_PWR_ONE     4'h2
`define SIC_OFS_PWR_TWO     4'h3
`define SIC_OFS_CLK_OUT     4'h4
`define SIC_OFS_GATE_ONE    4'h5
`define SIC_OFS_GATE_TWO    4'h6
`define SIC_OFS_GATE_THREE  4'h7

// ----------------------------------------------------------------------------
// Pin control fields
// ----------------------------------------------------------------------------
`define SIC_PIN_PULL_DIS    6
`define SIC_PIN_POL         5
`define SIC_PIN_ENABLE      4
`define SIC_PIN_FLAG        3
`define SIC_PIN_ACK         2
`define SIC_PIN_IE          1
`define SIC_PIN_MODE        0

// ----------------------------------------------------------------------------
// Power management fields
// ----------------------------------------------------------------------------
`define SIC_PWR_WARN_FLAG   7
`define SIC_PWR_WARN_ACK    6
`define SIC_PWR_WARN_IE     5
`define SIC_PWR_RST_EN      4
`define SIC_PWR_IN_STOP     3
`define SIC_PWR_DET_EN      2
`define SIC_PWR_BGAP_EN     0
`define SIC_PWR2_DET_LVL    5
`define SIC_PWR2_WARN_LVL   4

// ----------------------------------------------------------------------------
// Clock output fields, reset status fields
// ----------------------------------------------------------------------------
`define SIC_CLK_PIN_EN      4
`define SIC_CLK_SEL_MSB     2
`define SIC_RST_POR         7
`define SIC_RST_LVD         1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SIC_RST_PIN_CTRL    8'h00
`define SIC_RST_PWR_ONE     8'h1c
`define SIC_RST_PWR_TWO     8'h00
`define SIC_RST_CLK_OUT     8'h00
`define SIC_RST_GATE_ONE    8'h00
`define SIC_RST_GATE_TWO    8'h00
`define SIC_RST_GATE_THREE  8'h07

`endif

//--- sic_top.sv
// System integration control: interrupt pin, supply monitor, clock output, clock gating, reset status
// How it works
// R1 - Detection active only when enabled; level selectable
// R2 - Stop turns detection off unless kept; stop4
// R3 - Power-on sets power-on and low-voltage flags
// R4 - Low supply resets, held until recovery
// R5 - Warning flag with enable raises interrupt
// R6 - Writing warning acknowledge clears warning flag
// R7 - Acknowledge ignored while warning still present
// R8 - Clock pin outputs divided bus clock
// R9 - Output frequency is bus over twice select
// R10 - Clock output forces pin to output
// R11 - Zero select holds the pin low
// R12 - Reset leaves only flash, routing, DMA clocked
// R13 - Gating writes act immediately
// R14 - Writes to unclocked peripherals are dropped
// R15 - Stop removes all gated clocks
// R16 - Pull disable bit turns pull device off
// R17 - Polarity bit picks edge and pull direction
// R18 - Qualifying pin event sets the flag
// R19 - Acknowledge one clears flag, reads zero
// R20 - Level mode keeps flag while pin asserted
// R21 - Interrupt enable routes flag to request
// R22 - Mode bit adds level detection to edges
// R23 - Debug forced reset clears all status
// R24 - Reset status ignores writes
// R25 - Status bit layout, set if cause active
// R26 - Enabled pin can wake from stop
// R27 - Pin synchronised by two flip-flops
`timescale 1ns/100ps
`include "sic_regs.svh"
module sic_top (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire sic_pkg::sic_addr_t addr_i,
  input  wire sic_pkg::sic_byte_t wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output      sic_pkg::sic_byte_t rdata_o,
  input  wire logic             pin_i,
  input  wire logic             below_det_high_i,
  input  wire logic             below_det_low_i,
  input  wire logic             below_warn_high_i,
  input  wire logic             below_warn_low_i,
  input  wire logic [6:0]       reset_cause_i,
  input  wire logic             debug_forced_reset_i,
  input  wire logic             in_stop_i,
  input  wire logic             port_dir_i,
  input  wire logic             port_data_i,
  input  wire logic [23:0]      periph_wr_i,
  output      logic             pin_irq_o,
  output      logic             pin_pull_enable_o,
  output      logic             pin_pull_down_o,
  output      logic             pin_wake_arm_o,
  output      logic             supply_detect_active_o,
  output      logic             supply_level_high_o,
  output      logic             supply_reset_o,
  output      logic             supply_warn_irq_o,
  output      sic_pkg::sic_stop_e stop_mode_o,
  output      logic             shared_pin_o,
  output      logic             shared_pin_oe_o,
  output      logic [23:0]      periph_clk_en_o,
  output      logic [23:0]      periph_wr_o
);
  import sic_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  sic_int_if  link ();
  sic_byte_t  pin_ctrl_reg;
  sic_byte_t  rst_status_reg;
  logic       pin_ack_reg;
  logic       warn_flag_reg;
  logic       warn_ie_reg;
  logic       rst_en_reg;
  logic       rst_en_locked_reg;
  logic       in_stop_en_reg;
  logic       det_en_reg;
  logic       bgap_en_reg;
  logic       det_lvl_reg;
  logic       warn_lvl_reg;
  logic       clk_pin_en_reg;
  logic [2:0] clk_sel_reg;
  logic [23:0] gate_reg;
  logic [23:0] gate_next;
  logic [3:0] cmp_s1_reg;
  logic [3:0] cmp_s2_reg;
  logic       in_stop_prev_reg;
  sic_stop_e  stop_mode_reg;
  sic_byte_t  rdata_reg;
  logic       det_active;
  logic       det_low;
  logic       warn_cond;
  logic       warn_ack;

  function automatic logic wr_at(input sic_addr_t ofs);
    return wr_i && addr_i == ofs;
  endfunction

  // --------------------------------------------------------------------------
  // Supply comparator synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    cmp_s1_reg <= {below_det_high_i, below_det_low_i, below_warn_high_i, below_warn_low_i};
    cmp_s2_reg <= cmp_s1_reg;
  end

  // Detection off in deep stop unless kept alive
  assign det_active = det_en_reg && (stop_mode_reg == SIC_RUN || in_stop_en_reg); // [R1] [R2]
  assign det_low    = det_active && (det_lvl_reg ? cmp_s2_reg[3] : cmp_s2_reg[2]); // [R1]
  assign warn_cond  = det_active && (warn_lvl_reg ? cmp_s2_reg[1] : cmp_s2_reg[0]); // [R5]
  // Written out in full: a net driven through the function would miss strobe changes
  assign warn_ack   = wr_i && addr_i == `SIC_OFS_PWR_ONE && wdata_i[`SIC_PWR_WARN_ACK];

  // --------------------------------------------------------------------------
  // Interrupt pin control
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_ctrl_reg <= `SIC_RST_PIN_CTRL;
      pin_ack_reg  <= 1'b0;
    end else begin
      pin_ack_reg <= wr_at(`SIC_OFS_PIN_CTRL) && wdata_i[`SIC_PIN_ACK]; // [R19]
      if (wr_at(`SIC_OFS_PIN_CTRL)) begin
        // Reserved, flag and acknowledge positions are never stored
        pin_ctrl_reg <= wdata_i & 8'h73;
      end
    end
  end

  assign link.pin_en   = pin_ctrl_reg[`SIC_PIN_ENABLE];
  assign link.pin_pol  = pin_ctrl_reg[`SIC_PIN_POL];
  assign link.pin_mode = pin_ctrl_reg[`SIC_PIN_MODE]; // [R22]
  assign link.pin_ack  = pin_ack_reg;

  sic_pin_detect u_pin (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (pin_i),
    .bus     (link.det)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_irq_o         <= 1'b0;
      pin_pull_enable_o <= 1'b0;
      pin_pull_down_o   <= 1'b0;
      pin_wake_arm_o    <= 1'b0;
    end else begin
      pin_irq_o         <= link.pin_flag && pin_ctrl_reg[`SIC_PIN_IE]; // [R21]
      pin_pull_enable_o <= link.pin_en && !pin_ctrl_reg[`SIC_PIN_PULL_DIS]; // [R16]
      pin_pull_down_o   <= link.pin_en && !pin_ctrl_reg[`SIC_PIN_PULL_DIS] && link.pin_pol; // [R17]
      // Arms the asynchronous wake path; the path itself lives with the pad
      pin_wake_arm_o    <= link.pin_en; // [R26]
    end
  end

  // --------------------------------------------------------------------------
  // Power management and supply monitor
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      warn_ie_reg       <= 1'(`SIC_RST_PWR_ONE >> `SIC_PWR_WARN_IE);
      rst_en_reg        <= 1'(`SIC_RST_PWR_ONE >> `SIC_PWR_RST_EN);
      in_stop_en_reg    <= 1'(`SIC_RST_PWR_ONE >> `SIC_PWR_IN_STOP);
      det_en_reg        <= 1'(`SIC_RST_PWR_ONE >> `SIC_PWR_DET_EN);
      bgap_en_reg       <= 1'(`SIC_RST_PWR_ONE >> `SIC_PWR_BGAP_EN);
      rst_en_locked_reg <= 1'b0;
      det_lvl_reg       <= 1'(`SIC_RST_PWR_TWO >> `SIC_PWR2_DET_LVL);
      warn_lvl_reg      <= 1'(`SIC_RST_PWR_TWO >> `SIC_PWR2_WARN_LVL);
    end else begin
      if (wr_at(`SIC_OFS_PWR_ONE)) begin
        warn_ie_reg       <= wdata_i[`SIC_PWR_WARN_IE];
        in_stop_en_reg    <= wdata_i[`SIC_PWR_IN_STOP];
        det_en_reg        <= wdata_i[`SIC_PWR_DET_EN];
        bgap_en_reg       <= wdata_i[`SIC_PWR_BGAP_EN];
        rst_en_locked_reg <= 1'b1;
        // Reset enable accepts only the first write after reset
        if (!rst_en_locked_reg) begin
          rst_en_reg <= wdata_i[`SIC_PWR_RST_EN];
        end
      end
      if (wr_at(`SIC_OFS_PWR_TWO)) begin
        det_lvl_reg  <= wdata_i[`SIC_PWR2_DET_LVL];
        warn_lvl_reg <= wdata_i[`SIC_PWR2_WARN_LVL];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      warn_flag_reg <= 1'b0;
    end else begin
      // Condition present keeps the flag even against an acknowledge
      warn_flag_reg <= warn_cond || (warn_flag_reg && !warn_ack); // [R6] [R7]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      supply_detect_active_o <= 1'b0;
      supply_level_high_o    <= 1'b0;
      supply_reset_o         <= 1'b0;
      supply_warn_irq_o      <= 1'b0;
    end else begin
      supply_detect_active_o <= det_active; // [R1] [R2]
      supply_level_high_o    <= det_lvl_reg; // [R1]
      // Held as long as the supply stays below the trip point
      supply_reset_o         <= det_low && rst_en_reg; // [R4]
      supply_warn_irq_o      <= warn_flag_reg && warn_ie_reg; // [R5]
    end
  end

  // --------------------------------------------------------------------------
  // Stop mode selection
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      in_stop_prev_reg <= 1'b0;
      stop_mode_reg    <= SIC_RUN;
    end else begin
      in_stop_prev_reg <= in_stop_i;
      unique case (stop_mode_reg)
        SIC_RUN: begin
          if (in_stop_i && !in_stop_prev_reg) begin
            stop_mode_reg <= (det_en_reg && in_stop_en_reg) ? SIC_STOP4 : SIC_STOP_DEEP; // [R2]
          end
        end
        SIC_STOP_DEEP, SIC_STOP4: begin
          if (!in_stop_i) begin
            stop_mode_reg <= SIC_RUN;
          end
        end
        default: stop_mode_reg <= SIC_RUN;
      endcase
    end
  end

  assign stop_mode_o = stop_mode_reg;

  // --------------------------------------------------------------------------
  // Clock output pin
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clk_pin_en_reg <= 1'(`SIC_RST_CLK_OUT >> `SIC_CLK_PIN_EN);
      clk_sel_reg    <= 3'(`SIC_RST_CLK_OUT);
    end else if (wr_at(`SIC_OFS_CLK_OUT)) begin
      clk_pin_en_reg <= wdata_i[`SIC_CLK_PIN_EN];
      clk_sel_reg    <= wdata_i[`SIC_CLK_SEL_MSB:0];
    end
  end

  assign link.div_en  = clk_pin_en_reg; // [R8]
  assign link.div_sel = clk_sel_reg; // [R9]

  sic_clk_div u_div (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .bus     (link.div)
  );

  // Pad mux registered: one cycle late, but no glitch when the select flips
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shared_pin_o    <= 1'b0;
      shared_pin_oe_o <= 1'b0;
    end else begin
      shared_pin_o    <= clk_pin_en_reg ? link.div_out : port_data_i; // [R8] [R11]
      shared_pin_oe_o <= clk_pin_en_reg || port_dir_i; // [R10]
    end
  end

  // --------------------------------------------------------------------------
  // Peripheral clock gating
  // --------------------------------------------------------------------------
  always_comb begin
    gate_next = gate_reg;
    if (wr_at(`SIC_OFS_GATE_ONE)) begin
      gate_next[7:0] = wdata_i;
    end
    if (wr_at(`SIC_OFS_GATE_TWO)) begin
      gate_next[15:8] = wdata_i;
    end
    if (wr_at(`SIC_OFS_GATE_THREE)) begin
      gate_next[23:16] = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gate_reg        <= {`SIC_RST_GATE_THREE, `SIC_RST_GATE_TWO, `SIC_RST_GATE_ONE}; // [R12]
      periph_clk_en_o <= {`SIC_RST_GATE_THREE, `SIC_RST_GATE_TWO, `SIC_RST_GATE_ONE}; // [R12]
      periph_wr_o     <= 24'h000000;
    end else begin
      gate_reg        <= gate_next;
      // Enables follow the written value at the same edge, not a cycle later
      periph_clk_en_o <= in_stop_i ? 24'h000000 : gate_next; // [R13] [R15]
      periph_wr_o     <= periph_wr_i & periph_clk_en_o; // [R14]
    end
  end

  // --------------------------------------------------------------------------
  // Reset cause capture
  // --------------------------------------------------------------------------
  // Sampled every cycle of reset, so the last cycle before release wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      if (debug_forced_reset_i) begin
        rst_status_reg <= 8'h00; // [R23]
      end else begin
        rst_status_reg <= {reset_cause_i[6:1], reset_cause_i[0] | reset_cause_i[6], 1'b0}; // [R3] [R25]
      end
    end
    // Writes never reach this register [R24]
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i || !rd_i) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (addr_i)
        `SIC_OFS_PIN_CTRL:   rdata_reg <= pin_ctrl_reg | {4'h0, link.pin_flag, 3'h0}; // [R19]
        `SIC_OFS_RST_STATUS: rdata_reg <= rst_status_reg;
        `SIC_OFS_PWR_ONE:    rdata_reg <= {warn_flag_reg, 1'b0, warn_ie_reg, rst_en_reg,
                                           in_stop_en_reg, det_en_reg, 1'b0, bgap_en_reg};
        `SIC_OFS_PWR_TWO:    rdata_reg <= {2'h0, det_lvl_reg, warn_lvl_reg, 4'h0};
        `SIC_OFS_CLK_OUT:    rdata_reg <= {3'h0, clk_pin_en_reg, 1'b0, clk_sel_reg};
        `SIC_OFS_GATE_ONE:   rdata_reg <= gate_reg[7:0];
        `SIC_OFS_GATE_TWO:   rdata_reg <= gate_reg[15:8];
        `SIC_OFS_GATE_THREE: rdata_reg <= gate_reg[23:16];
        default:             rdata_reg <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rdata_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_detect_disabled: assert property (!det_en_reg |=> !supply_reset_o && !supply_detect_active_o) // [R1]
    else $error("Supply detection active while disabled");
  a_stop4_select: assert property (stop_mode_reg == SIC_RUN && in_stop_i && !in_stop_prev_reg
                                   && det_en_reg && in_stop_en_reg |=> stop_mode_reg == SIC_STOP4) // [R2]
    else $error("Stop4 not chosen with detection kept in stop");
  a_low_resets: assert property (det_low && rst_en_reg |=> supply_reset_o) // [R4]
    else $error("Low supply did not hold reset");
  a_warn_irq: assert property (warn_flag_reg && warn_ie_reg |=> supply_warn_irq_o) // [R5]
    else $error("Warning interrupt missing");
  a_warn_ack_clear: assert property (warn_ack && !warn_cond |=> !warn_flag_reg) // [R6]
    else $error("Warning acknowledge did not clear");
  a_warn_ack_kept: assert property (warn_ack && warn_cond |=> warn_flag_reg) // [R7]
    else $error("Warning cleared while condition present");
  a_clk_pin_out: assert property (clk_pin_en_reg |=> shared_pin_oe_o) // [R10]
    else $error("Clock pin not forced to output");
  a_gate_write: assert property (wr_i && addr_i == `SIC_OFS_GATE_ONE && !in_stop_i
                                 |=> periph_clk_en_o[7:0] == $past(wdata_i)) // [R13]
    else $error("Gating write not applied at once");
  a_gate_stop: assert property (in_stop_i |=> periph_clk_en_o == 24'h000000) // [R15]
    else $error("Gated clock running in stop");
  a_status_ro: assert property (wr_i |=> $stable(rst_status_reg)) // [R24]
    else $error("Reset status changed by a write");
  a_pin_irq: assert property (link.pin_flag && pin_ctrl_reg[`SIC_PIN_IE] |=> pin_irq_o) // [R21]
    else $error("Pin interrupt request missing");

  c_pin_event: cover property (pin_irq_o);
  c_warn_ack: cover property (warn_ack ##1 !warn_flag_reg);
  c_stop4: cover property (stop_mode_reg == SIC_STOP4);
  c_clk_out: cover property (clk_pin_en_reg && clk_sel_reg == 3'h3 && $rose(shared_pin_o));
endmodule

//--- test_system_integration_control.sv
// Self-checking bench for the system integration control block
`timescale 1ns/100ps
module test_system_integration_control;
  import sic_pkg::*;
  logic        clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, dbg = 0, stp = 0;
  sic_addr_t   addr_i = 4'h0;
  sic_byte_t   wdata_i = 8'h00, rdata_o, r, v;
  logic [23:0] pw = 24'h0, pwo, cen;
  logic        pin, pl = 1, wrn = 0, pe, pd, bwh, bwl, bdh, bdl, irq, wirq, sp, oe, p;
  logic        lo = 0, wake, dact, lvh, srst;
  sic_stop_e   sm;
  int          num_errors = 0, total_checks = 0, cyc = 0, n, c;
  sic_byte_t   rst_tab [9] = '{8'h00, 8'h82, 8'h1c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
  always #2.5 clk_i = ~clk_i;
  sic_top uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin), .below_det_high_i(bdh), .below_det_low_i(bdl),
    .below_warn_high_i(bwh), .below_warn_low_i(bwl), .reset_cause_i(7'h40),
    .debug_forced_reset_i(dbg), .in_stop_i(stp), .port_dir_i(1'b0), .port_data_i(1'b0),
    .periph_wr_i(pw), .pin_irq_o(irq), .pin_pull_enable_o(pe), .pin_pull_down_o(pd),
    .pin_wake_arm_o(wake), .supply_detect_active_o(dact), .supply_level_high_o(lvh), .supply_reset_o(srst),
    .supply_warn_irq_o(wirq), .stop_mode_o(sm), .shared_pin_o(sp), .shared_pin_oe_o(oe),
    .periph_clk_en_o(cen), .periph_wr_o(pwo));
  sic_far_model fm (.pin_lvl_i(pl), .warn_i(wrn), .low_i(lo), .pin_o(pin), .below_det_high_o(bdh),
    .below_det_low_o(bdl), .below_warn_high_o(bwh), .below_warn_low_o(bwl));
  function automatic logic [23:0] gate_exp(input sic_byte_t g);
    return {8'h07, 8'h00, g};
  endfunction
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input sic_addr_t a, input sic_byte_t d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input sic_addr_t a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run is under two hundred cycles; generous ceiling
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    void'($urandom(38252));
    w(3);
    reset_i <= 1'b0;
    chk(cen, 24'h070000);
    for (int i = 0; i < 9; i++) begin
      rd(i[3:0]);
      chk(r, rst_tab[i]);
    end
    wr(1, 8'hff);
    rd(1);
    chk(r, 8'h82);
    $display("map test done");
    wr(0, 8'h12);
    w(4);
    pl = 0;
    w(5);
    chk(irq, 1);
    chk(wake, 1);
    rd(0);
    chk(r, 8'h1a);
    wr(0, 8'h16);
    w(2);
    rd(0);
    chk(r, 8'h12);
    chk({pe, pd}, 2'b10);
    wr(0, 8'h32);
    w(2);
    chk({pe, pd}, 2'b11);
    wr(0, 8'h72);
    w(2);
    chk({pe, pd}, 2'b00);
    wr(0, 8'h00);
    pl = 1;
    w(4);
    wr(0, 8'h13);
    w(4);
    pl = 0;
    w(5);
    wr(0, 8'h17);
    w(2);
    rd(0);
    chk(r, 8'h1b);
    pl = 1;
    w(4);
    wr(0, 8'h17);
    w(2);
    rd(0);
    chk(r, 8'h13);
    $display("pin test done");
    wr(2, 8'h3c);
    wrn <= 1'b1;
    w(6);
    chk(wirq, 1);
    wr(2, 8'h7c);
    w(2);
    rd(2);
    chk(r, 8'hbc);
    wrn = 0;
    w(4);
    wr(2, 8'h7c);
    w(2);
    rd(2);
    chk(r, 8'h3c);
    wr(3, 8'h20);
    lo <= 1'b1;
    w(4);
    chk({dact, lvh, srst}, 3'b111);
    lo <= 1'b0;
    w(4);
    chk(srst, 0);
    $display("warning test done");
    n = $urandom_range(7, 1);
    wr(4, 8'h10 | n[7:0]);
    w(3);
    chk(oe, 1);
    for (int k = 0; k < 3; k++) begin
      c = 0;
      p = sp;
      while (sp === p && c < 20) begin
        w(1);
        c++;
      end
    end
    chk(c, n);
    wr(4, 8'h10);
    w(4);
    chk(sp, 0);
    $display("clock out test done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      wr(5, v);
      pw <= 24'($urandom);
      w(3);
      chk(cen, gate_exp(v));
      chk(pwo, pw & gate_exp(v));
    end
    stp <= 1'b1;
    w(3);
    chk(cen, 0);
    chk(sm, SIC_STOP4);
    stp <= 1'b0;
    dbg <= 1'b1;
    reset_i <= 1'b1;
    w(3);
    reset_i <= 1'b0;
    rd(1);
    chk(r, 8'h00);
    wr(2, 8'h04);
    stp <= 1'b1;
    w(3);
    chk({sm, dact}, {SIC_STOP_DEEP, 1'b0});
    $display("gating and reset test done");
    summarize;
  end
endmodule
